// ==== core/csf_alu.sv ====
// combinational 8-bit alu with flag generation
// assumes the core drives op and operands through the interface
`timescale 1ns/1ps
`default_nettype none
module csf_alu
    import csf_pkg::*;
(
    csf_alu_if.alu bus
);
    logic [8:0] sum;
    logic [4:0] nib;
    logic [7:0] bx;
    logic       c7;

    always_comb begin
        bx  = (bus.op == CSF_OP_SUB) ? ~bus.b : bus.b;
        sum = 9'h000;
        nib = 5'h00;
        c7  = 1'b0;
        bus.res = 8'h00;
        bus.c   = bus.cin;
        bus.hc  = 1'b0;
        bus.vf  = 1'b0;
        case (bus.op)
            CSF_OP_ADD, CSF_OP_SUB: begin
                // subtract as a + ~b + 1 so carry means no borrow
                sum = {1'b0, bus.a} + {1'b0, bx} + {8'h00, (bus.op == CSF_OP_SUB)};
                nib = {1'b0, bus.a[3:0]} + {1'b0, bx[3:0]} + {4'h0, (bus.op == CSF_OP_SUB)};
                c7  = bus.a[7] ^ bx[7] ^ sum[7];
                bus.res = sum[7:0];
                bus.c   = sum[8];
                bus.hc  = nib[4];
                bus.vf  = c7 ^ sum[8];
            end
            CSF_OP_AND: bus.res = bus.a & bus.b;
            CSF_OP_OR:  bus.res = bus.a | bus.b;
            CSF_OP_XOR: bus.res = bus.a ^ bus.b;
            CSF_OP_RLC: begin
                bus.res = {bus.a[6:0], bus.cin};
                bus.c   = bus.a[7];
            end
            CSF_OP_RRC: begin
                bus.res = {bus.cin, bus.a[7:1]};
                bus.c   = bus.a[0];
            end
            CSF_OP_INC: bus.res = bus.a + 8'h01;
            CSF_OP_DEC: bus.res = bus.a - 8'h01;
            default:    bus.res = bus.a;
        endcase
        bus.z = (bus.res == 8'h00);
    end
endmodule : csf_alu
`default_nettype wire

// ==== core/csf_alu_if.sv ====
// alu request and result bundle between the core block and its alu
// assumes both ends share core_clk; purely combinational signals
`timescale 1ns/1ps
`default_nettype none
interface csf_alu_if;
    import csf_pkg::*;
    csf_op_t    op;
    logic [7:0] a;
    logic [7:0] b;
    logic       cin;
    logic [7:0] res;
    logic       c;
    logic       hc;
    logic       z;
    logic       vf;
    modport core (output op, a, b, cin, input res, c, hc, z, vf);
    modport alu  (input op, a, b, cin, output res, c, hc, z, vf);
endinterface : csf_alu_if
`default_nettype wire

// ==== core/csf_core.sv ====
// core special registers: working register, page jump, table read, status, irq control
// assumes axi4-lite master on core_clk; program memory answers table reads combinationally
`timescale 1ns/1ps
`default_nettype none
module csf_core
    import csf_pkg::*;
(
    // clock and reset
    input  wire  logic        core_clk,
    input  wire  logic        reset_n,
    // axi4-lite write
    input  wire  logic [7:0]  s_axi_awaddr,
    input  wire  logic        s_axi_awvalid,
    output logic              s_axi_awready,
    input  wire  logic [31:0] s_axi_wdata,
    input  wire  logic [3:0]  s_axi_wstrb,
    input  wire  logic        s_axi_wvalid,
    output logic              s_axi_wready,
    output logic [1:0]        s_axi_bresp,
    output logic              s_axi_bvalid,
    input  wire  logic        s_axi_bready,
    // axi4-lite read
    input  wire  logic [7:0]  s_axi_araddr,
    input  wire  logic        s_axi_arvalid,
    output logic              s_axi_arready,
    output logic [31:0]       s_axi_rdata,
    output logic [1:0]        s_axi_rresp,
    output logic              s_axi_rvalid,
    input  wire  logic        s_axi_rready,
    // program memory table port
    output logic [12:0]       table_addr,
    input  wire  logic [15:0] table_word,
    // core events
    input  wire  logic        watchdog_timeout,
    input  wire  logic        irq_entry,
    // program flow
    output logic [12:0]       program_counter,
    output logic              dummy_cycle,
    output logic [7:0]        ext_irq_edge_select,
    output logic              global_irq_enable
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0] working_register_q, working_register_d;
    logic [7:0] program_counter_low_byte_q, program_counter_low_byte_d;
    logic [4:0] page_q, page_d;
    logic [7:0] table_pointer_low_q, table_pointer_low_d;
    logic [7:0] table_pointer_high_q, table_pointer_high_d;
    logic [7:0] table_data_high_latch_q, table_data_high_latch_d;
    logic [7:0] table_data_low_q, table_data_low_d;
    logic [7:0] status_q, status_d;
    logic [7:0] irq_control_first_q, irq_control_first_d;
    logic [7:0] edge_q, edge_d;
    logic       dummy_q, dummy_d;

    // bus slave state
    logic        aw_q, aw_d, w_q, w_d, b_q, b_d, r_q, r_d;
    logic [7:0]  awaddr_q, awaddr_d;
    logic [31:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [3:0]  wstrb_q, wstrb_d;
    logic [1:0]  bresp_q, bresp_d, rresp_q, rresp_d;

    csf_alu_if alu_bus ();
    csf_alu csf_alu_i (.bus(alu_bus));

    logic       wr_fire;
    logic [7:0] wbyte;
    logic       is_arith;
    csf_op_t    op_sel;

    function automatic logic known_addr(input logic [7:0] a);
        known_addr = (a[1:0] == 2'b00) && (a <= OFS_TDL);
    endfunction : known_addr

    // ------------------------------------------------------------
    // axi4-lite slave
    // ------------------------------------------------------------
    assign s_axi_awready = !aw_q && !b_q;
    assign s_axi_wready  = !w_q && !b_q;
    assign s_axi_arready = !r_q;
    assign s_axi_bvalid  = b_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_rvalid  = r_q;
    assign s_axi_rdata   = rdata_q;
    assign s_axi_rresp   = rresp_q;
    assign wr_fire       = aw_q && w_q && !b_q;
    assign wbyte         = wdata_q[7:0];

    always_comb begin
        aw_d = aw_q; w_d = w_q; b_d = b_q; r_d = r_q;
        awaddr_d = awaddr_q; wdata_d = wdata_q; wstrb_d = wstrb_q;
        bresp_d = bresp_q; rresp_d = rresp_q; rdata_d = rdata_q;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_d = 1'b1;
            awaddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_d = 1'b0;
            w_d  = 1'b0;
            b_d  = 1'b1;
            bresp_d = known_addr(awaddr_q) ? 2'b00 : 2'b10;
        end else if (b_q && s_axi_bready) begin
            b_d = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            r_d = 1'b1;
            rresp_d = known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
            if (s_axi_araddr == OFS_WORK) rdata_d = {24'h0, working_register_q};
            else if (s_axi_araddr == OFS_PC_LOW) rdata_d = {24'h0, program_counter_low_byte_q};
            else if (s_axi_araddr == OFS_TPL) rdata_d = {24'h0, table_pointer_low_q};
            else if (s_axi_araddr == OFS_TPH) rdata_d = {24'h0, table_pointer_high_q};
            else if (s_axi_araddr == OFS_TDH) rdata_d = {24'h0, table_data_high_latch_q};
            else if (s_axi_araddr == OFS_STATUS) rdata_d = {24'h0, status_q};
            else if (s_axi_araddr == OFS_IRQCTL) rdata_d = {24'h0, irq_control_first_q};
            else if (s_axi_araddr == OFS_EDGE) rdata_d = {24'h0, edge_q};
            else if (s_axi_araddr == OFS_PCH) rdata_d = {27'h0, page_q};
            else if (s_axi_araddr == OFS_TDL) rdata_d = {24'h0, table_data_low_q};
            else rdata_d = 32'h0;
        end else if (r_q && s_axi_rready) begin
            r_d = 1'b0;
        end
    end

    // ------------------------------------------------------------
    // alu operand selection
    // ------------------------------------------------------------
    always_comb begin
        op_sel = CSF_OP_NONE;
        if (wr_fire && awaddr_q == OFS_OP && wstrb_q[0]) begin
            op_sel = csf_op_t'(wbyte[3:0]);
        end
        alu_bus.op  = op_sel;
        alu_bus.a   = working_register_q;
        alu_bus.b   = wdata_q[15:8];
        alu_bus.cin = status_q[ST_C];
    end

    assign is_arith = (op_sel == CSF_OP_ADD) || (op_sel == CSF_OP_SUB) ||
                      (op_sel == CSF_OP_AND) || (op_sel == CSF_OP_OR) ||
                      (op_sel == CSF_OP_XOR) || (op_sel == CSF_OP_RLC) ||
                      (op_sel == CSF_OP_RRC) || (op_sel == CSF_OP_INC) ||
                      (op_sel == CSF_OP_DEC);

    // ------------------------------------------------------------
    // special registers
    // ------------------------------------------------------------
    always_comb begin
        working_register_d         = working_register_q;
        program_counter_low_byte_d = program_counter_low_byte_q;
        page_d                     = page_q;
        table_pointer_low_d        = table_pointer_low_q;
        table_pointer_high_d       = table_pointer_high_q;
        table_data_high_latch_d    = table_data_high_latch_q;
        table_data_low_d           = table_data_low_q;
        status_d                   = status_q;
        irq_control_first_d        = irq_control_first_q;
        edge_d                     = edge_q;
        dummy_d                    = 1'b0;
        if (wr_fire && wstrb_q[0]) begin
            // only the working register and the page take a plain move; table data latches ignore writes, others load from the working register
            if (awaddr_q == OFS_WORK) working_register_d = wbyte;
            else if (awaddr_q == OFS_PC_LOW) begin
                program_counter_low_byte_d = working_register_q;
                dummy_d = 1'b1;
            end
            else if (awaddr_q == OFS_PCH) page_d = wbyte[4:0];
            else if (awaddr_q == OFS_TPL) table_pointer_low_d = working_register_q;
            else if (awaddr_q == OFS_TPH) table_pointer_high_d = working_register_q;
            else if (awaddr_q == OFS_STATUS) begin
                // flags other than power-down and expiry behave as plain bits
                status_d = (status_q & ~ST_ARITH_MASK) | (working_register_q & ST_ARITH_MASK);
            end
            else if (awaddr_q == OFS_IRQCTL) irq_control_first_d = working_register_q;
            else if (awaddr_q == OFS_EDGE) edge_d = working_register_q;
        end
        if (is_arith) begin
            working_register_d = alu_bus.res;
            status_d[ST_Z]  = alu_bus.z;
            if (op_sel != CSF_OP_AND && op_sel != CSF_OP_OR && op_sel != CSF_OP_XOR &&
                op_sel != CSF_OP_INC && op_sel != CSF_OP_DEC) begin
                status_d[ST_C]  = alu_bus.c;
            end
            if (op_sel == CSF_OP_ADD || op_sel == CSF_OP_SUB) begin
                status_d[ST_NIB] = alu_bus.hc;
                status_d[ST_SRF] = alu_bus.vf;
            end
        end
        if (op_sel == CSF_OP_TBRD) begin
            table_data_high_latch_d = table_word[15:8];
            table_data_low_d        = table_word[7:0];
        end
        if (op_sel == CSF_OP_WDCLR) begin
            status_d[ST_PWDN] = 1'b0;
            status_d[ST_WDX]  = 1'b0;
        end
        if (op_sel == CSF_OP_HALT) begin
            status_d[ST_PWDN] = 1'b1;
            status_d[ST_WDX]  = 1'b0;
        end
        // timeout wins over a clear in the same cycle
        if (watchdog_timeout) status_d[ST_WDX] = 1'b1;
        // entry leaves status alone; only the global enable drops
        if (irq_entry || op_sel == CSF_OP_IRQIN) begin
            irq_control_first_d[IRQ_GLOBAL] = 1'b0;
        end else if (op_sel == CSF_OP_IRQEX) begin
            irq_control_first_d[IRQ_GLOBAL] = 1'b1;
        end
        status_d[7:6] = 2'b00;
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            working_register_q         <= RST_BYTE;
            program_counter_low_byte_q <= RST_BYTE;
            page_q                     <= RST_PAGE;
            table_pointer_low_q        <= RST_BYTE;
            table_pointer_high_q       <= RST_BYTE;
            table_data_high_latch_q    <= RST_BYTE;
            table_data_low_q           <= RST_BYTE;
            status_q                   <= RST_BYTE;
            irq_control_first_q        <= RST_BYTE;
            edge_q                     <= RST_BYTE;
            dummy_q                    <= 1'b0;
            aw_q <= 1'b0; w_q <= 1'b0; b_q <= 1'b0; r_q <= 1'b0;
            awaddr_q <= 8'h00; wdata_q <= 32'h0; wstrb_q <= 4'h0;
            bresp_q <= 2'b00; rresp_q <= 2'b00; rdata_q <= 32'h0;
        end else begin
            working_register_q         <= working_register_d;
            program_counter_low_byte_q <= program_counter_low_byte_d;
            page_q                     <= page_d;
            table_pointer_low_q        <= table_pointer_low_d;
            table_pointer_high_q       <= table_pointer_high_d;
            table_data_high_latch_q    <= table_data_high_latch_d;
            table_data_low_q           <= table_data_low_d;
            status_q                   <= status_d;
            irq_control_first_q        <= irq_control_first_d;
            edge_q                     <= edge_d;
            dummy_q                    <= dummy_d;
            aw_q <= aw_d; w_q <= w_d; b_q <= b_d; r_q <= r_d;
            awaddr_q <= awaddr_d; wdata_q <= wdata_d; wstrb_q <= wstrb_d;
            bresp_q <= bresp_d; rresp_q <= rresp_d; rdata_q <= rdata_d;
        end
    end

    assign table_addr          = {table_pointer_high_q[4:0], table_pointer_low_q};
    assign program_counter     = {page_q, program_counter_low_byte_q};
    assign dummy_cycle         = dummy_q;
    assign ext_irq_edge_select = edge_q;
    assign global_irq_enable   = irq_control_first_q[IRQ_GLOBAL];

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // reference values built apart from the alu, so the checks do not echo it
    logic [8:0] chk_sum;
    logic [4:0] chk_nib;
    logic       chk_ovf;
    logic       chk_no_borrow;
    assign chk_sum       = {1'b0, working_register_q} + {1'b0, wdata_q[15:8]};
    assign chk_nib       = {1'b0, working_register_q[3:0]} + {1'b0, wdata_q[11:8]};
    assign chk_ovf       = (working_register_q[7] == wdata_q[15]) && (chk_sum[7] != working_register_q[7]);
    assign chk_no_borrow = (working_register_q >= wdata_q[15:8]);

    sequence s_pc_low_write;
        wr_fire && wstrb_q[0] && awaddr_q == OFS_PC_LOW;
    endsequence
    sequence s_tpl_write;
        wr_fire && wstrb_q[0] && awaddr_q == OFS_TPL;
    endsequence

    a_pc_low_jump: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_pc_low_write |=> program_counter == {$past(page_q), $past(working_register_q)})
        else $error("pc low write did not jump within page");
    a_pc_low_dummy: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_pc_low_write |=> dummy_cycle ##1 !dummy_cycle)
        else $error("dummy cycle missing after pc low write");
    a_status_keep_sys: assert property (@(posedge core_clk) disable iff (!reset_n)
        (wr_fire && awaddr_q == OFS_STATUS && op_sel == CSF_OP_NONE && !watchdog_timeout)
        |=> $stable(status_q[ST_WDX:ST_PWDN]))
        else $error("status write changed system flags");
    a_halt_sets_pwdn: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_HALT |=> status_q[ST_PWDN])
        else $error("halt did not set power-down flag");
    a_pwdn_only_halt: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(status_q[ST_PWDN]) |-> $past(op_sel) == CSF_OP_HALT)
        else $error("power-down flag rose without halt");
    a_wdx_only_timeout: assert property (@(posedge core_clk) disable iff (!reset_n)
        $rose(status_q[ST_WDX]) |-> $past(watchdog_timeout))
        else $error("expiry flag rose without timeout");
    a_wdclr_clears_sys: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_sel == CSF_OP_WDCLR && !watchdog_timeout) |=> status_q[ST_WDX:ST_PWDN] == 2'b00)
        else $error("watchdog clear left system flags set");
    a_entry_clears_gie: assert property (@(posedge core_clk) disable iff (!reset_n)
        irq_entry |=> !global_irq_enable)
        else $error("irq entry left global enable set");
    a_return_from_irq_sets_gie: assert property (@(posedge core_clk) disable iff (!reset_n)
        (op_sel == CSF_OP_IRQEX && !irq_entry) |=> global_irq_enable)
        else $error("return did not set global enable");
    a_zero_flag_res: assert property (@(posedge core_clk) disable iff (!reset_n)
        is_arith |=> status_q[ST_Z] == (working_register_q == 8'h00))
        else $error("zero flag disagrees with result");
    a_add_carry: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_ADD |=> status_q[ST_C] == $past(chk_sum[8]))
        else $error("add carry wrong");
    a_sub_no_borrow: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_SUB |=> status_q[ST_C] == $past(chk_no_borrow))
        else $error("subtract carry wrong");
    a_add_nibble_carry: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_ADD |=> status_q[ST_NIB] == $past(chk_nib[4]))
        else $error("add nibble carry wrong");
    a_add_overflow: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_ADD |=> status_q[ST_SRF] == $past(chk_ovf))
        else $error("add overflow wrong");
    a_status_top_zero: assert property (@(posedge core_clk) disable iff (!reset_n)
        status_q[7:6] == 2'b00)
        else $error("unused status bits set");
    a_pointer_via_work: assert property (@(posedge core_clk) disable iff (!reset_n)
        s_tpl_write |=> table_pointer_low_q == $past(working_register_q))
        else $error("pointer not loaded from working register");
    a_table_latch_hi: assert property (@(posedge core_clk) disable iff (!reset_n)
        op_sel == CSF_OP_TBRD |=> table_data_high_latch_q == $past(table_word[15:8]))
        else $error("table high latch not loaded");
    a_flags_hold_move: assert property (@(posedge core_clk) disable iff (!reset_n)
        (!is_arith && !(wr_fire && awaddr_q == OFS_STATUS)) |=> $stable(status_q[3:0]))
        else $error("arithmetic flags changed on a move");
endmodule : csf_core
`default_nettype wire

// ==== core/csf_pkg.sv ====
// package for the core status flags and special registers block
// assumes one clock domain and an axi4-lite register bus
package csf_pkg;

    // register byte offsets
    localparam logic [7:0] OFS_WORK     = 8'h00;
    localparam logic [7:0] OFS_PC_LOW   = 8'h04;
    localparam logic [7:0] OFS_TPL      = 8'h08;
    localparam logic [7:0] OFS_TPH      = 8'h0C;
    localparam logic [7:0] OFS_TDH      = 8'h10;
    localparam logic [7:0] OFS_STATUS   = 8'h14;
    localparam logic [7:0] OFS_IRQCTL   = 8'h18;
    localparam logic [7:0] OFS_EDGE     = 8'h1C;
    localparam logic [7:0] OFS_OP       = 8'h20;
    localparam logic [7:0] OFS_PCH      = 8'h24;
    localparam logic [7:0] OFS_TDL      = 8'h28;

    // status field positions
    localparam int ST_C    = 0;
    localparam int ST_NIB  = 1;
    localparam int ST_Z    = 2;
    localparam int ST_SRF  = 3;
    localparam int ST_PWDN = 4;
    localparam int ST_WDX  = 5;
    localparam logic [7:0] ST_ARITH_MASK = 8'h0F;

    // irq control field: bit 0 global enable, bits 7..1 source enables
    localparam int IRQ_GLOBAL = 0;

    // reset values
    localparam logic [7:0] RST_BYTE   = 8'h00;
    localparam logic [4:0] RST_PAGE   = 5'h00;

    // operation codes written to the op register
    typedef enum logic [3:0] {
        CSF_OP_NONE  = 4'h0,
        CSF_OP_ADD   = 4'h1,
        CSF_OP_SUB   = 4'h2,
        CSF_OP_AND   = 4'h3,
        CSF_OP_OR    = 4'h4,
        CSF_OP_XOR   = 4'h5,
        CSF_OP_RLC   = 4'h6,
        CSF_OP_RRC   = 4'h7,
        CSF_OP_TBRD  = 4'h8,
        CSF_OP_WDCLR = 4'h9,
        CSF_OP_HALT  = 4'hA,
        CSF_OP_IRQIN = 4'hB,
        CSF_OP_IRQEX = 4'hC,
        CSF_OP_INC   = 4'hD,
        CSF_OP_DEC   = 4'hE
    } csf_op_t;

endpackage : csf_pkg

// ==== dv/csf_core_tb.sv ====
// directed bench for the core special registers over axi4-lite
// assumes csf_pkg offsets and a program memory word held steady
`timescale 1ns/1ps
`default_nettype none
module csf_core_tb;
    import csf_pkg::*;
    // ----------------------------------------
    // stimulus and observed signals
    // ----------------------------------------
    logic        core_clk   = 1'b0;
    logic        reset_n    = 1'b0;
    logic [7:0]  awaddr     = 8'h00;
    logic [7:0]  araddr     = 8'h00;
    logic        awvalid    = 1'b0;
    logic        wvalid     = 1'b0;
    logic        bready     = 1'b0;
    logic        arvalid    = 1'b0;
    logic        rready     = 1'b0;
    logic [31:0] wdata      = 32'h0;
    logic [15:0] table_word = 16'hABCD;
    logic        wd_exp     = 1'b0;
    logic        irq_in     = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid, dummy_cycle, gie;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    logic [12:0] table_addr, program_counter;
    logic [7:0]  edge_sel;
    logic [31:0] rd_val;
    logic [1:0]  rd_resp, wr_resp;
    int          miscompares = 0;
    int          check_count = 0;
    int          dummy_n     = 0;
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) if (dummy_cycle === 1'b1) dummy_n <= dummy_n + 1;
    csf_core csf_core_i (.core_clk(core_clk), .reset_n(reset_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .table_addr(table_addr),
        .table_word(table_word), .watchdog_timeout(wd_exp), .irq_entry(irq_in), .program_counter(program_counter),
        .dummy_cycle(dummy_cycle), .ext_irq_edge_select(edge_sel), .global_irq_enable(gie));
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : summarize
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    // one write; both channels offered together, bready held until bvalid
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit got;
        got = 1'b0;
        @(posedge core_clk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge core_clk);
            if (awvalid && awready === 1'b1) awvalid <= 1'b0;
            if (wvalid && wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) begin
                got = 1'b1;
                wr_resp = bresp;
                bready <= 1'b0;
            end
        end
        if (!got) begin
            miscompares++;
            summarize();
        end
    endtask : axi_wr
    task automatic axi_rd(input logic [7:0] a);
        bit got;
        got = 1'b0;
        @(posedge core_clk);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        for (int n = 0; n < 50 && !got; n++) begin
            @(posedge core_clk);
            if (arvalid && arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) begin
                got     = 1'b1;
                rd_val  = rdata;
                rd_resp = rresp;
                rready <= 1'b0;
            end
        end
        if (!got) begin
            miscompares++;
            summarize();
        end
    endtask : axi_rd
    task automatic rd_chk(input string name, input logic [7:0] a, input logic [7:0] exp);
        axi_rd(a);
        check(name, rd_val, {24'h0, exp});
    endtask : rd_chk
    // moves always go through the working register
    task automatic mov(input logic [7:0] a, input logic [7:0] v);
        axi_wr(OFS_WORK, {24'h0, v});
        axi_wr(a, 32'h0);
    endtask : mov
    task automatic op(input csf_op_t code, input logic [7:0] b);
        axi_wr(OFS_OP, {16'h0, b, 4'h0, code});
    endtask : op
    // one-cycle pulse on irq entry or on the watchdog expiry input
    task automatic pulse(input bit irq);
        @(posedge core_clk);
        if (irq) irq_in <= 1'b1;
        else wd_exp <= 1'b1;
        @(posedge core_clk);
        irq_in <= 1'b0;
        wd_exp <= 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : pulse
    // ----------------------------------------
    // directed sequence
    // ----------------------------------------
    initial begin
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        rd_chk("status_reset", OFS_STATUS, 8'h00);
        mov(OFS_STATUS, 8'hFF);
        rd_chk("status_from_work", OFS_STATUS, 8'h0F);
        $display("test moves done");
        axi_wr(OFS_WORK, 32'h7F);
        op(CSF_OP_ADD, 8'h01);
        rd_chk("add_result", OFS_WORK, 8'h80);
        rd_chk("add_flags", OFS_STATUS, 8'h0A);
        axi_wr(OFS_WORK, 32'h05);
        op(CSF_OP_SUB, 8'h05);
        rd_chk("sub_flags", OFS_STATUS, 8'h07);
        axi_wr(OFS_WORK, 32'h0F);
        rd_chk("move_keeps_flags", OFS_STATUS, 8'h07);
        op(CSF_OP_OR, 8'h00);
        rd_chk("or_flags", OFS_STATUS, 8'h03);
        mov(OFS_STATUS, 8'h00);
        axi_wr(OFS_WORK, 32'h80);
        op(CSF_OP_RLC, 8'h00);
        rd_chk("rlc_flags", OFS_STATUS, 8'h05);
        $display("test arithmetic done");
        op(CSF_OP_HALT, 8'h00);
        rd_chk("halt_sets_pwdn", OFS_STATUS, 8'h15);
        pulse(1'b0);
        rd_chk("timeout_sets", OFS_STATUS, 8'h35);
        mov(OFS_STATUS, 8'h00);
        rd_chk("write_keeps_sys", OFS_STATUS, 8'h30);
        op(CSF_OP_HALT, 8'h00);
        rd_chk("halt_clears_wdx", OFS_STATUS, 8'h10);
        op(CSF_OP_WDCLR, 8'h00);
        rd_chk("clear_both", OFS_STATUS, 8'h00);
        $display("test system flags done");
        axi_wr(OFS_PCH, 32'h03);
        mov(OFS_PC_LOW, 8'h34);
        repeat (3) @(negedge core_clk);
        check("page_jump", {19'h0, program_counter}, 32'h0334);
        check("dummy_pulses", dummy_n, 32'd1);
        mov(OFS_TPL, 8'h12);
        mov(OFS_TPH, 8'h01);
        op(CSF_OP_TBRD, 8'h00);
        @(negedge core_clk);
        check("table_addr", {19'h0, table_addr}, 32'h0112);
        rd_chk("table_high", OFS_TDH, 8'hAB);
        rd_chk("table_low", OFS_TDL, 8'hCD);
        $display("test jump and table done");
        mov(OFS_IRQCTL, 8'h81);
        @(negedge core_clk);
        check("global_on", {31'h0, gie}, 32'h1);
        pulse(1'b1);
        check("entry_clears", {31'h0, gie}, 32'h0);
        rd_chk("status_not_saved", OFS_STATUS, 8'h00);
        op(CSF_OP_IRQEX, 8'h00);
        rd_chk("return_sets", OFS_IRQCTL, 8'h81);
        mov(OFS_EDGE, 8'h05);
        @(negedge core_clk);
        check("edge_select", {24'h0, edge_sel}, 32'h05);
        axi_wr(OFS_WORK, 32'hFF);
        op(CSF_OP_INC, 8'h00);
        rd_chk("inc_flags", OFS_STATUS, 8'h04);
        op(CSF_OP_DEC, 8'h00);
        rd_chk("dec_result", OFS_WORK, 8'hFF);
        op(CSF_OP_AND, 8'h0F);
        op(CSF_OP_XOR, 8'h0F);
        rd_chk("and_xor_flags", OFS_STATUS, 8'h04);
        axi_wr(OFS_WORK, 32'h01);
        op(CSF_OP_RRC, 8'h00);
        rd_chk("rrc_flags", OFS_STATUS, 8'h05);
        axi_wr(OFS_WORK, 32'h80);
        op(CSF_OP_ADD, 8'h80);
        rd_chk("carry_out_ovf", OFS_STATUS, 8'h0D);
        op(CSF_OP_IRQIN, 8'h00);
        rd_chk("entry_op_clears", OFS_IRQCTL, 8'h80);
        check("mapped_bresp", {30'h0, wr_resp}, 32'h0);
        axi_wr(8'h30, 32'h0);
        check("unmapped_bresp", {30'h0, wr_resp}, 32'h2);
        axi_rd(8'h30);
        check("unmapped_resp", {30'h0, rd_resp}, 32'h2);
        check("unmapped_data", rd_val, 32'h0);
        $display("test irq and bus done");
        summarize();
    end
endmodule : csf_core_tb
`default_nettype wire
